// >>> hw/tmo_pkg.sv
`default_nettype none
package tmo_pkg;
  // ***************
  // addresses
  // ***************
  localparam logic [7:0] TMO_OFF_CTL2 = 8'h04;
  localparam logic [7:0] TMO_OFF_AUX  = 8'h40;
  localparam logic [7:0] TMO_OFF_CHAN = 8'h44;
  localparam logic [7:0] TMO_OFF_SWEV = 8'h48;
  // ***************
  // control two fields
  // ***************
  localparam int TMO_B_SHEN  = 0;
  localparam int TMO_B_LDSRC = 2;
  localparam int TMO_B_DMA_SOURCE_SELECT  = 3;
  localparam int TMO_B_MM    = 4;
  localparam int TMO_B_IDL0  = 8;
  localparam int TMO_B_IDL0N = 9;
  localparam int TMO_B_IDL1  = 10;
  localparam logic [10:0] TMO_CTL2_WMASK = 11'h07_7D;
  localparam logic [10:0] TMO_CTL2_IDLM  = 11'h07_00;
  localparam logic [10:0] TMO_CTL2_RST   = 11'h00_00;
  // ***************
  // aux, channel and software event fields
  // ***************
  localparam int TMO_B_PRIMARY_OUTPUT_ENABLE  = 0;
  localparam int TMO_B_PROT  = 1;
  localparam int TMO_B_CEN   = 3;
  localparam int TMO_B_UPDATE_DISABLE_BIT = 4;
  localparam int TMO_B_UPS   = 5;
  localparam logic [5:0] TMO_AUX_RST = 6'h00;
  localparam int TMO_B_C0EN  = 0;
  localparam int TMO_B_C0NEN = 1;
  localparam int TMO_B_C0MD  = 2;
  localparam int TMO_B_C1EN  = 8;
  localparam int TMO_B_C1MD  = 10;
  localparam int TMO_B_UPG   = 0;
  localparam int TMO_B_SOFTWARE_COMMUTATION_GENERATE  = 1;
  // ***************
  // timing
  // ***************
  localparam int TMO_CLK_MHZ = 40;
  localparam int TMO_DT_NS   = 200;
  localparam logic [7:0] TMO_DT_CYC =
    8'((TMO_DT_NS * TMO_CLK_MHZ + 999) / 1000);
  // ***************
  // types
  // ***************
  typedef enum logic [2:0] {
    TMO_MM_RESET  = 3'b000,
    TMO_MM_START  = 3'b001,
    TMO_MM_UPDATE = 3'b010,
    TMO_MM_CH0EVT = 3'b011,
    TMO_MM_OREF0  = 3'b100,
    TMO_MM_OREF1  = 3'b101
  } tmo_mm_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tmo_bus_t;
  typedef struct packed {
    logic       c0_en;
    logic       c0_nen;
    logic [2:0] c0_md;
    logic       c1_en;
    logic [2:0] c1_md;
  } tmo_chan_t;
  typedef struct packed {
    logic master_rst;
    logic overflow;
    logic restart;
    logic pause_mode;
    logic trig_in;
    logic ch0_cap;
    logic ch0_cmp;
    logic ch1_cap;
    logic ch1_cmp;
    logic oref0;
    logic oref1;
  } tmo_evt_t;
endpackage : tmo_pkg
`default_nettype wire

// >>> hw/tmo_ctl.sv
`default_nettype none
module tmo_ctl
  import tmo_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire tmo_pkg::tmo_bus_t bus,
  output var  logic [31:0]       rdata,
  input  wire tmo_pkg::tmo_evt_t evt,
  input  wire logic              ch0_ref,
  input  wire logic              ch0n_ref,
  input  wire logic              ch1_ref,
  output var  logic              ch0_out,
  output var  logic              ch0n_out,
  output var  logic              ch1_out,
  output var  logic              master_trigger_output,
  output var  logic [1:0]        dma_req,
  output var  tmo_pkg::tmo_chan_t chan
);
  import tmo_pkg::*;

  // ***************
  // state
  // ***************
  typedef struct packed {
    logic [10:0] ctl;
    logic [5:0]  aux;
    tmo_chan_t   act;
    tmo_chan_t   shd;
    logic [7:0]  dt;
    logic        primary_output_enable_p;
    logic        trig_p;
    logic        pz_p;
    logic [1:0]  oref_p;
    logic        master_trigger_output;
    logic [1:0]  dma;
    logic        o0;
    logic        o0n;
    logic        o1;
    logic [31:0] rdata;
  } tmo_st_t;

  tmo_st_t st_q;
  tmo_st_t st_d;

  // ***************
  // decode
  // ***************
  logic wr_ctl;
  logic wr_aux;
  logic wr_chan;
  logic wr_swev;
  logic software_update_generate;
  logic software_commutation_generate;
  logic cen_set;
  logic trig_rise;
  logic pz_rise;
  logic upd_evt;
  logic cmt_evt;
  logic prot_open;
  logic primary_output_enable;
  logic [10:0] ctl_w;
  tmo_chan_t   chan_w;

  always_comb
  begin
    wr_ctl  = 1'b0;
    wr_aux  = 1'b0;
    wr_chan = 1'b0;
    wr_swev = 1'b0;
    if (bus.wr && bus.addr == TMO_OFF_CTL2)
    begin
      wr_ctl = 1'b1;
    end
    else if (bus.wr && bus.addr == TMO_OFF_AUX)
    begin
      wr_aux = 1'b1;
    end
    else if (bus.wr && bus.addr == TMO_OFF_CHAN)
    begin
      wr_chan = 1'b1;
    end
    else if (bus.wr && bus.addr == TMO_OFF_SWEV)
    begin
      wr_swev = 1'b1;
    end
  end

  // ***************
  // event sources
  // ***************
  assign software_update_generate  = wr_swev & bus.wdata[TMO_B_UPG];
  assign software_commutation_generate = wr_swev & bus.wdata[TMO_B_SOFTWARE_COMMUTATION_GENERATE];
  assign cen_set = wr_aux & bus.wdata[TMO_B_CEN]
                 & ~st_q.aux[TMO_B_CEN];
  // trigger input already lives on this clock, no synchroniser
  assign trig_rise = evt.trig_in & ~st_q.trig_p;
  assign pz_rise = evt.pause_mode & evt.trig_in & ~st_q.pz_p;
  assign upd_evt = ~st_q.aux[TMO_B_UPDATE_DISABLE_BIT]
                 & (software_update_generate | evt.overflow | evt.restart);
  assign cmt_evt = software_commutation_generate
                 | (st_q.ctl[TMO_B_LDSRC] & trig_rise);
  assign prot_open = st_q.aux[TMO_B_PROT +: 2] == 2'b00;
  assign primary_output_enable = st_q.aux[TMO_B_PRIMARY_OUTPUT_ENABLE];

  always_comb
  begin
    ctl_w = bus.wdata[10:0] & TMO_CTL2_WMASK;
    // locked idle bits keep their old value
    if (!prot_open)
    begin
      ctl_w = (ctl_w & ~TMO_CTL2_IDLM)
            | (st_q.ctl & TMO_CTL2_IDLM);
    end
  end

  assign chan_w.c0_en  = bus.wdata[TMO_B_C0EN];
  assign chan_w.c0_nen = bus.wdata[TMO_B_C0NEN];
  assign chan_w.c0_md  = bus.wdata[TMO_B_C0MD +: 3];
  assign chan_w.c1_en  = bus.wdata[TMO_B_C1EN];
  assign chan_w.c1_md  = bus.wdata[TMO_B_C1MD +: 3];

  // ***************
  // next state
  // ***************
  always_comb
  begin
    st_d = st_q;
    st_d.trig_p = evt.trig_in;
    st_d.pz_p   = evt.pause_mode & evt.trig_in;
    st_d.oref_p = {evt.oref1, evt.oref0};
    st_d.primary_output_enable_p = primary_output_enable;
    st_d.rdata  = 32'h0000_0000;

    if (wr_ctl)
    begin
      st_d.ctl = ctl_w;
    end
    if (wr_aux)
    begin
      st_d.aux = bus.wdata[5:0];
    end

    // channel fields: channel 1 has no complementary output
    if (wr_chan)
    begin
      st_d.act.c1_en = chan_w.c1_en;
      st_d.act.c1_md = chan_w.c1_md;
      if (!st_q.ctl[TMO_B_SHEN])
      begin
        st_d.act.c0_en  = chan_w.c0_en;
        st_d.act.c0_nen = chan_w.c0_nen;
        st_d.act.c0_md  = chan_w.c0_md;
      end
      else
      begin
        st_d.shd = chan_w;
      end
    end
    if (st_q.ctl[TMO_B_SHEN] && cmt_evt)
    begin
      // same-cycle write goes straight through
      st_d.act.c0_en  = wr_chan ? chan_w.c0_en  : st_q.shd.c0_en;
      st_d.act.c0_nen = wr_chan ? chan_w.c0_nen : st_q.shd.c0_nen;
      st_d.act.c0_md  = wr_chan ? chan_w.c0_md  : st_q.shd.c0_md;
    end

    // master trigger selection
    case (tmo_mm_t'(st_q.ctl[TMO_B_MM +: 3]))
      TMO_MM_RESET:  st_d.master_trigger_output = evt.master_rst | software_update_generate;
      TMO_MM_START:  st_d.master_trigger_output = cen_set | pz_rise;
      TMO_MM_UPDATE: st_d.master_trigger_output = upd_evt;
      TMO_MM_CH0EVT: st_d.master_trigger_output = evt.ch0_cap
                               | evt.ch0_cmp;
      TMO_MM_OREF0:  st_d.master_trigger_output = evt.oref0
                               & ~st_q.oref_p[0];
      TMO_MM_OREF1:  st_d.master_trigger_output = evt.oref1
                               & ~st_q.oref_p[1];
      default:       st_d.master_trigger_output = 1'b0;
    endcase

    // dma requests: channel events, or the update event on both lines when selected
    if (st_q.ctl[TMO_B_DMA_SOURCE_SELECT])
    begin
      st_d.dma = {2{upd_evt}};
    end
    else
    begin
      st_d.dma = {evt.ch1_cap | evt.ch1_cmp,
                  evt.ch0_cap | evt.ch0_cmp};
    end

    // dead-time counter, loaded when outputs switch off while c0_nen is set
    if (st_q.primary_output_enable_p && !primary_output_enable && st_q.act.c0_nen)
    begin
      st_d.dt = TMO_DT_CYC;
    end
    else if (st_q.dt != 8'h00)
    begin
      st_d.dt = st_q.dt - 8'h01;
    end

    // output levels
    if (primary_output_enable)
    begin
      st_d.o0  = st_q.act.c0_en & ch0_ref;
      st_d.o0n = st_q.act.c0_nen & ch0n_ref;
      st_d.o1  = st_q.act.c1_en & ch1_ref;
    end
    else
    begin
      st_d.o0n = st_q.ctl[TMO_B_IDL0N];
      st_d.o1  = st_q.ctl[TMO_B_IDL1];
      // main output holds until the dead-time ends
      if (st_q.dt == 8'h00 &&
          !(st_q.primary_output_enable_p && st_q.act.c0_nen))
      begin
        st_d.o0 = st_q.ctl[TMO_B_IDL0];
      end
    end

    // read port, answer in next cycle only
    if (bus.rd)
    begin
      if (bus.addr == TMO_OFF_CTL2)
      begin
        st_d.rdata = {21'h00_0000, st_q.ctl};
      end
      else if (bus.addr == TMO_OFF_AUX)
      begin
        st_d.rdata = {26'h000_0000, st_q.aux};
      end
      else if (bus.addr == TMO_OFF_CHAN)
      begin
        st_d.rdata = {19'h0_0000, st_q.act.c1_md, 1'b0,
                      st_q.act.c1_en, 3'h0, st_q.act.c0_md,
                      st_q.act.c0_nen, st_q.act.c0_en};
      end
    end
  end

  // ***************
  // registers
  // ***************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q        <= '0;
      st_q.ctl    <= TMO_CTL2_RST;
      st_q.aux    <= TMO_AUX_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rdata    = st_q.rdata;
  assign ch0_out  = st_q.o0;
  assign ch0n_out = st_q.o0n;
  assign ch1_out  = st_q.o1;
  assign master_trigger_output     = st_q.master_trigger_output;
  assign dma_req  = st_q.dma;
  assign chan     = st_q.act;
endmodule // tmo_ctl
`default_nettype wire

// >>> testbench/tmo_far_model.sv
`default_nettype none
// ***************
// slave timer side: counts master trigger pulses
// ***************
module tmo_far_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       master_trigger_output,
  output var  logic [7:0] trg_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  // a slave only sees pulses, so a stuck-high trigger inflates the count
  always_ff @(posedge clk)
  begin
    if (srst)
      trg_cnt <= 8'h00;
    else if (master_trigger_output)
      trg_cnt <= trg_cnt + 8'h01;
  end
endmodule // tmo_far_model
`default_nettype wire

// >>> testbench/tmo_monitor.sv
`default_nettype none
module tmo_monitor (
  input wire logic              clk,
  input wire logic              srst,
  input wire tmo_pkg::tmo_bus_t bus,
  input wire logic [31:0]       rdata,
  input wire tmo_pkg::tmo_evt_t evt,
  input wire logic              ch0_out,
  input wire logic              ch0n_out,
  input wire logic              ch1_out,
  input wire logic              master_trigger_output,
  input wire logic [1:0]        dma_req
);
  timeunit 1ns;
  timeprecision 100ps;
  import tmo_pkg::*;
  // ***************
  // field shadows
  // ***************
  logic [2:0] mm_q;
  logic [2:0] idl_q;
  logic       dma_source_select_q;
  logic       primary_output_enable_q;
  logic       lock_q;
  wire  logic wr_ctl = bus.wr && bus.addr == TMO_OFF_CTL2;
  wire  logic wr_aux = bus.wr && bus.addr == TMO_OFF_AUX;
  always_ff @(posedge clk)
  begin
    if (srst)
      {mm_q, idl_q, dma_source_select_q, primary_output_enable_q, lock_q} <= '0;
    else
    begin
      if (wr_ctl)
        {mm_q, dma_source_select_q} <= bus.wdata[6:3];
      if (wr_ctl && !lock_q)
        idl_q <= bus.wdata[10:8];
      if (wr_aux)
        {lock_q, primary_output_enable_q} <= {|bus.wdata[2:1], bus.wdata[0]};
    end
  end
  // ***************
  // properties
  // ***************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // long quiet spell so the dead-time wait is surely over
  // eight dead-time counts plus load, output stage and sampling edge: eleven samples
  sequence seq_quiet_off;
    (!primary_output_enable_q && $stable(idl_q))[*8] ##1 (!primary_output_enable_q && $stable(idl_q))[*3];
  endsequence
  chk_rd_quiet: assert property (!bus.rd |=> rdata == 32'h0)
    else $error("read data outside slot");
  chk_mm_reset: assert property (mm_q == 3'h0 && evt.master_rst |=> master_trigger_output)
    else $error("no trigger on reset");
  chk_mm_chevt: assert property (mm_q == 3'h3 && evt.ch0_cap |=> master_trigger_output)
    else $error("no trigger on capture");
  chk_mm_oref: assert property (mm_q == 3'h4 && $rose(evt.oref0) |=> master_trigger_output)
    else $error("no trigger on reference");
  chk_mm_rsvd: assert property (mm_q[2:1] == 2'h3 |=> !master_trigger_output)
    else $error("trigger in reserved mode");
  chk_dma_cc: assert property (!dma_source_select_q && evt.ch0_cmp |=> dma_req[0])
    else $error("no dma on compare");
  chk_idle_pins: assert property ((!primary_output_enable_q)[*2] |->
    ch0n_out == $past(idl_q[1]) && ch1_out == $past(idl_q[2]))
    else $error("idle level wrong");
  chk_idle_main: assert property (seq_quiet_off |->
    ch0_out == $past(idl_q[0]))
    else $error("main idle level wrong");
endmodule // tmo_monitor
bind tmo_ctl tmo_monitor u_mon (.clk(clk), .srst(srst), .bus(bus),
  .rdata(rdata), .evt(evt), .ch0_out(ch0_out), .ch0n_out(ch0n_out),
  .ch1_out(ch1_out), .master_trigger_output(master_trigger_output), .dma_req(dma_req));
`default_nettype wire

// >>> testbench/tmo_ctl_tb.sv
`default_nettype none
module tmo_ctl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tmo_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  tmo_bus_t    bus = '0;
  tmo_evt_t    evt = '0;
  logic [31:0] rdata;
  logic        ch0_out;
  logic        ch0n_out;
  logic        ch1_out;
  logic        master_trigger_output;
  logic [1:0]  dma_req;
  tmo_chan_t   chan;
  logic [7:0]  trg_cnt;
  int          err_count = 0;
  int          checks = 0;
  always #12.5 clk = ~clk;
  tmo_ctl u_dut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
    .evt(evt), .ch0_ref(1'b1), .ch0n_ref(1'b0), .ch1_ref(1'b1),
    .ch0_out(ch0_out), .ch0n_out(ch0n_out), .ch1_out(ch1_out),
    .master_trigger_output(master_trigger_output), .dma_req(dma_req), .chan(chan));
  tmo_far_model u_far (.clk(clk), .srst(srst), .master_trigger_output(master_trigger_output),
    .trg_cnt(trg_cnt));
  // ***************
  // bus and compare tasks
  // ***************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= {a, d, 2'b10};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= {a, 32'h0, 2'b01};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // one-cycle event, then trigger and dma seen in the following cycle
  task automatic pulse(input tmo_evt_t v, input logic [2:0] exp);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= '0;
    #1;
    chk(32'({master_trigger_output, dma_req}), 32'(exp));
  endtask
  function automatic tmo_evt_t ev(input int e);
    tmo_evt_t v;
    v = '0;
    case (e)
      0: v.master_rst = 1'b1;
      1: {v.pause_mode, v.trig_in} = 2'b11;
      2: v.overflow = 1'b1;
      3: v.ch0_cap = 1'b1;
      4: v.oref0 = 1'b1;
      5: v.oref1 = 1'b1;
      6: v.ch0_cmp = 1'b1;
      7: v.ch1_cmp = 1'b1;
      default: v.restart = 1'b1;
    endcase
    return v;
  endfunction
  // ***************
  // scenarios
  // ***************
  task automatic t_rw;
    rd(TMO_OFF_CTL2, 32'h0);
    rd(8'h20, 32'h0);
    wr(TMO_OFF_CTL2, 32'h0000_077D);
    rd(TMO_OFF_CTL2, 32'h0000_077D);
    wr(TMO_OFF_AUX, 32'h2);
    wr(TMO_OFF_CTL2, 32'h0);
    rd(TMO_OFF_CTL2, 32'h0000_0700);
    wr(TMO_OFF_AUX, 32'h0);
  endtask
  task automatic t_modes;
    logic [7:0] c0;
    c0 = trg_cnt;
    for (int m = 0; m < 8; m++)
    begin
      wr(TMO_OFF_CTL2, 32'(m) << 4);
      for (int e = 0; e < 6; e++)
        pulse(ev(e), {m == e, 1'b0, e == 3});
    end
    chk(32'(trg_cnt - c0), 32'h6);
  endtask
  task automatic t_sw;
    wr(TMO_OFF_CTL2, 32'h0);
    wr(TMO_OFF_SWEV, 32'h1);
    chk(32'(master_trigger_output), 32'h1);
    wr(TMO_OFF_CTL2, 32'h0000_0010);
    wr(TMO_OFF_AUX, 32'h8);
    chk(32'(master_trigger_output), 32'h1);
    wr(TMO_OFF_AUX, 32'h8);
    chk(32'(master_trigger_output), 32'h0);
    wr(TMO_OFF_CTL2, 32'h0000_0020);
    wr(TMO_OFF_AUX, 32'h0000_0010);
    pulse(ev(2), 3'h0);
    wr(TMO_OFF_CTL2, 32'h8);
    wr(TMO_OFF_AUX, 32'h0);
    pulse(ev(3), 3'h0);
    pulse(ev(2), 3'h3);
    wr(TMO_OFF_CTL2, 32'h0000_0030);
    pulse(ev(6), 3'h5);
    pulse(ev(7), 3'h2);
    wr(TMO_OFF_CTL2, 32'h0000_0020);
    pulse(ev(8), 3'h4);
  endtask
  task automatic t_idle;
    wr(TMO_OFF_CHAN, 32'h0000_0103);
    chk(32'(chan), 32'h0000_0188);
    wr(TMO_OFF_AUX, 32'h1);
    wr(TMO_OFF_CTL2, 32'h0000_0200);
    chk(32'({ch0_out, ch0n_out, ch1_out}), 32'h5);
    wr(TMO_OFF_AUX, 32'h0);
    @(posedge clk);
    #1;
    chk(32'({ch0_out, ch0n_out, ch1_out}), 32'h6);
    repeat (10) @(posedge clk);
    #1;
    chk(32'(ch0_out), 32'h0);
  endtask
  task automatic t_shadow;
    wr(TMO_OFF_CTL2, 32'h0000_0201);
    wr(TMO_OFF_CHAN, 32'h0000_000C);
    chk(32'(chan), 32'h0000_0180);
    wr(TMO_OFF_SWEV, 32'h2);
    chk(32'(chan), 32'h0000_0030);
    wr(TMO_OFF_CHAN, 32'h0000_0103);
    pulse(ev(1), 3'h0);
    chk(32'(chan), 32'h0000_0038);
    wr(TMO_OFF_CTL2, 32'h0000_0205);
    pulse(ev(1), 3'h0);
    chk(32'(chan), 32'h0000_0188);
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_rw();
    t_modes();
    t_sw();
    t_idle();
    t_shadow();
    report_and_stop();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule // tmo_ctl_tb
`default_nettype wire
